// [rtl/cwd_pkg.sv]
// package: field layout, encodings and register offsets of the configuration word decoder
package cwd_pkg;
   // register indices on the software read port (word addresses)
   localparam logic [3:0] ADDR_DEBUG = 4'h0;
   localparam logic [3:0] ADDR_POWER = 4'h1;
   localparam logic [3:0] ADDR_WDOG = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_RUNCTL = 4'h4;
   localparam logic [3:0] ADDR_TIMEOUT = 4'h5;
   // debug word fields
   localparam int DBG_CHAN_LSB = 3;
   localparam int DBG_SCAN_BIT = 2;
   // power word fields
   localparam int PWR_LPBOR_BIT = 3;
   localparam int PWR_RETVOFF_BIT = 2;
   localparam int PWR_BOMODE_LSB = 0;
   // watchdog word fields
   localparam int WD_ON_BIT = 15;
   localparam int WD_CLK_LSB = 13;
   localparam int WD_RUNPS_LSB = 8;
   localparam int WD_WINDOW_DISABLE_BIT = 7;
   localparam int WD_WINSZ_LSB = 5;
   localparam int WD_SLPPS_LSB = 0;
   // runtime control bits
   localparam int CTL_SWBOR_BIT = 0;
   localparam int CTL_RUNTIME_RETENTION_EN_BIT = 1;
   localparam int CTL_SLEEP_BIT = 2;
   // erased flash reads all ones
   localparam logic [31:0] WORD_ERASED = 32'hffffffff;
   localparam logic [4:0] PS_MAX_CODE = 5'h14;
   typedef enum logic [1:0] {CWD_CHAN_NONE, CWD_CHAN_P3, CWD_CHAN_P2, CWD_CHAN_P1} cwd_chan_t;
   typedef enum logic [1:0] {CWD_BO_OFF, CWD_BO_SW, CWD_BO_RUN, CWD_BO_HW} cwd_bomode_t;
   typedef enum logic [1:0] {CWD_CLK_SYS, CWD_CLK_RSVD, CWD_CLK_FRC, CWD_CLK_LOW_POWER_RC_OSC} cwd_wclk_t;
   // window size in eighths of the period: 11=2/8, 10=3/8, 01=4/8, 00=6/8
   localparam logic [3:0] WIN_25 = 4'h2;
   localparam logic [3:0] WIN_375 = 4'h3;
   localparam logic [3:0] WIN_50 = 4'h4;
   localparam logic [3:0] WIN_75 = 4'h6;
   typedef struct packed {
      logic [2:0] prog_pin_pair;
      logic boundary_scan_en;
   } cwd_debug_t;
   typedef struct packed {
      logic brownout_reset_en;
      logic low_power_brownout_on;
      logic retention_regulator_on;
   } cwd_power_t;
   typedef struct packed {
      logic watchdog_on;
      logic [1:0] clk_src;
      logic windowed;
      logic [3:0] window_eighths;
      logic [4:0] postscale_exp;
   } cwd_wdog_t;
endpackage

// [rtl/cwd_config_word_decode.sv]
// config_word_decode: latches configuration words on the first edge after reset release and decodes control settings
//
// Summary of operation
// - debug channel field selects programming pin pair
// - scan enable bit turns JTAG port on
// - low power detector enable bit, on only when main off
// - retention regulator off bit, else follows retention enable while sleeping
// - mode 11 forces brown-out reset always on
// - mode 10 brown-out only while running
// - mode 01 software bit decides; 00 off
// - watchdog enable bit turns watchdog on
// - run clock field selects watchdog clock source
// - run postscale is two to code, saturating
// - window disable bit selects normal mode
// - window size field sets window fraction
// - sleep postscale uses same saturating encoding
// - sleep always clocks watchdog from low-power oscillator
`timescale 1ns/10ps
module cwd_config_word_decode (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [31:0] i_debug_word,
   input wire logic [31:0] i_power_word,
   input wire logic [31:0] i_wdog_word,
   input wire logic i_sleep,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output cwd_pkg::cwd_debug_t o_debug,
   output cwd_pkg::cwd_power_t o_power,
   output cwd_pkg::cwd_wdog_t o_wdog,
   output logic [20:0] o_timeout_ticks
);
   // ==========================================================
   // sleep synchroniser
   logic sleep_s1_reg;
   logic sleep_s1_next;
   logic sleep_s2_reg;
   logic sleep_s2_next;
   logic sleeping;

   // sleep comes from the power controller domain; only the second flop is read
   always_comb begin
      sleep_s1_next = i_sleep;
      sleep_s2_next = sleep_s1_reg;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         sleep_s1_reg <= 1'b0;
         sleep_s2_reg <= 1'b0;
      end else begin
         sleep_s1_reg <= sleep_s1_next;
         sleep_s2_reg <= sleep_s2_next;
      end
   end

   assign sleeping = sleep_s2_reg;

   // ==========================================================
   // word capture
   logic [31:0] dbg_reg;
   logic [31:0] dbg_next;
   logic [31:0] pwr_reg;
   logic [31:0] pwr_next;
   logic [31:0] wd_reg;
   logic [31:0] wd_next;
   logic loaded_reg;
   logic loaded_next;

   // words are sampled on the first edge after reset release, so a strap
   // that settles during reset is caught, then frozen until the next reset
   always_comb begin
      dbg_next = dbg_reg;
      pwr_next = pwr_reg;
      wd_next = wd_reg;
      loaded_next = 1'b1;
      if (!loaded_reg) begin
         dbg_next = i_debug_word;
         pwr_next = i_power_word;
         wd_next = i_wdog_word;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         dbg_reg <= cwd_pkg::WORD_ERASED;
         pwr_reg <= cwd_pkg::WORD_ERASED;
         wd_reg <= cwd_pkg::WORD_ERASED;
         loaded_reg <= 1'b0;
      end else begin
         dbg_reg <= dbg_next;
         pwr_reg <= pwr_next;
         wd_reg <= wd_next;
         loaded_reg <= loaded_next;
      end
   end

   // ==========================================================
   // runtime control
   logic [2:0] ctl_reg;
   logic [2:0] ctl_next;
   logic ctl_wr_hit;
   logic sw_bor;
   logic runtime_retention_en;

   // only the runtime control word is writable; config words ignore writes
   always_comb begin
      ctl_wr_hit = i_wr && (i_addr == cwd_pkg::ADDR_RUNCTL);
      ctl_next = ctl_reg;
      if (ctl_wr_hit) begin
         ctl_next = i_wdata[2:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ctl_reg <= 3'h0;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   assign sw_bor = ctl_reg[cwd_pkg::CTL_SWBOR_BIT];
   assign runtime_retention_en = ctl_reg[cwd_pkg::CTL_RUNTIME_RETENTION_EN_BIT];

   // ==========================================================
   // debug decode
   cwd_pkg::cwd_debug_t debug_next;
   cwd_pkg::cwd_chan_t chan;

   always_comb begin
      chan = cwd_pkg::cwd_chan_t'(dbg_reg[cwd_pkg::DBG_CHAN_LSB +: 2]);
      debug_next.prog_pin_pair = 3'h0;
      unique case (chan)
         cwd_pkg::CWD_CHAN_P1: begin
            debug_next.prog_pin_pair = 3'h1;
         end
         cwd_pkg::CWD_CHAN_P2: begin
            debug_next.prog_pin_pair = 3'h2;
         end
         cwd_pkg::CWD_CHAN_P3: begin
            debug_next.prog_pin_pair = 3'h4;
         end
         cwd_pkg::CWD_CHAN_NONE: begin
            debug_next.prog_pin_pair = 3'h0;
         end
      endcase
      debug_next.boundary_scan_en = dbg_reg[cwd_pkg::DBG_SCAN_BIT];
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_debug <= '0;
      end else begin
         o_debug <= debug_next;
      end
   end

   // ==========================================================
   // power decode
   cwd_pkg::cwd_power_t power_next;
   cwd_pkg::cwd_bomode_t bomode;
   logic lp_bor_allowed;
   logic ret_allowed;

   always_comb begin
      bomode = cwd_pkg::cwd_bomode_t'(pwr_reg[cwd_pkg::PWR_BOMODE_LSB +: 2]);
      lp_bor_allowed = pwr_reg[cwd_pkg::PWR_LPBOR_BIT];
      ret_allowed = !pwr_reg[cwd_pkg::PWR_RETVOFF_BIT];
      power_next.brownout_reset_en = 1'b0;
      unique case (bomode)
         cwd_pkg::CWD_BO_HW: begin
            power_next.brownout_reset_en = 1'b1;
         end
         cwd_pkg::CWD_BO_RUN: begin
            power_next.brownout_reset_en = !sleeping;
         end
         cwd_pkg::CWD_BO_SW: begin
            power_next.brownout_reset_en = sw_bor;
         end
         cwd_pkg::CWD_BO_OFF: begin
            power_next.brownout_reset_en = 1'b0;
         end
      endcase
      power_next.low_power_brownout_on = lp_bor_allowed
         & !power_next.brownout_reset_en;
      // the regulator only matters in sleep; awake it is reported off
      power_next.retention_regulator_on = ret_allowed & sleeping & runtime_retention_en;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_power <= '0;
      end else begin
         o_power <= power_next;
      end
   end

   // ==========================================================
   // watchdog decode
   cwd_pkg::cwd_wdog_t wdog_next;
   logic [4:0] ps_code;
   logic [4:0] ps_exp;
   logic [1:0] win_code;

   always_comb begin
      wdog_next.watchdog_on = wd_reg[cwd_pkg::WD_ON_BIT];
      // reserved clock code 01 is passed through; the watchdog treats it as its own choice
      if (sleeping) begin
         wdog_next.clk_src = 2'(cwd_pkg::CWD_CLK_LOW_POWER_RC_OSC);
         ps_code = wd_reg[cwd_pkg::WD_SLPPS_LSB +: 5];
      end else begin
         wdog_next.clk_src = wd_reg[cwd_pkg::WD_CLK_LSB +: 2];
         ps_code = wd_reg[cwd_pkg::WD_RUNPS_LSB +: 5];
      end
      // every code above the cap gives the longest ratio
      if (ps_code > cwd_pkg::PS_MAX_CODE) begin
         ps_exp = cwd_pkg::PS_MAX_CODE;
      end else begin
         ps_exp = ps_code;
      end
      wdog_next.postscale_exp = ps_exp;
      wdog_next.windowed = !wd_reg[cwd_pkg::WD_WINDOW_DISABLE_BIT];
      win_code = wd_reg[cwd_pkg::WD_WINSZ_LSB +: 2];
      unique case (win_code)
         2'h3: begin
            wdog_next.window_eighths = cwd_pkg::WIN_25;
         end
         2'h2: begin
            wdog_next.window_eighths = cwd_pkg::WIN_375;
         end
         2'h1: begin
            wdog_next.window_eighths = cwd_pkg::WIN_50;
         end
         2'h0: begin
            wdog_next.window_eighths = cwd_pkg::WIN_75;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_wdog <= '0;
      end else begin
         o_wdog <= wdog_next;
      end
   end

   // ==========================================================
   // timeout
   logic [20:0] timeout_next;

   // ticks of the selected source clock; the watchdog applies the source
   // period itself, so no clock rate has to be known here
   always_comb begin
      timeout_next = 21'h1 << ps_exp;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_timeout_ticks <= 21'h0;
      end else begin
         o_timeout_ticks <= timeout_next;
      end
   end

   // ==========================================================
   // register readback
   logic [31:0] rdata_next;
   logic [31:0] status_word;

   always_comb begin
      status_word = {19'h0, power_next, wdog_next.clk_src, wdog_next.watchdog_on,
         debug_next.boundary_scan_en, debug_next.prog_pin_pair, 2'h0, sleeping};
      rdata_next = 32'h0;
      if (i_rd) begin
         unique case (i_addr)
            cwd_pkg::ADDR_DEBUG: rdata_next = dbg_reg;
            cwd_pkg::ADDR_POWER: rdata_next = pwr_reg;
            cwd_pkg::ADDR_WDOG: rdata_next = wd_reg;
            cwd_pkg::ADDR_STATUS: rdata_next = status_word;
            cwd_pkg::ADDR_RUNCTL: rdata_next = {29'h0, ctl_reg};
            cwd_pkg::ADDR_TIMEOUT: rdata_next = {11'h0, timeout_next};
            default: rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rdata <= 32'h0;
      end else begin
         o_rdata <= rdata_next;
      end
   end
endmodule

// [test/cwd_assertions.sv]
// port checks for the configuration word decoder
`timescale 1ns/10ps
module cwd_assertions (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_rd,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] o_rdata,
   input cwd_pkg::cwd_debug_t o_debug,
   input cwd_pkg::cwd_power_t o_power,
   input cwd_pkg::cwd_wdog_t o_wdog,
   input wire logic [20:0] o_timeout_ticks
);
   // ==========
   // settle count: decoded outputs and the sleep sync lag reset release
   logic [2:0] up_reg;
   logic [2:0] up_next;
   assign up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
   always_ff @(posedge i_clk) up_reg <= i_sys_rst ? 3'h0 : up_next;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   a_rdata_zero: assert property (
      (!$past(i_rd) || $past(i_addr) > 4'h5) |-> o_rdata == 32'h0) else $error("rdata not zero");
   a_ticks_pow: assert property (
      up_reg == 3'h7 |-> o_timeout_ticks == 21'h1 << o_wdog.postscale_exp) else $error("ticks");
   a_ps_sat: assert property (
      o_wdog.postscale_exp <= 5'h14) else $error("postscale above cap");
   a_pins_onehot: assert property (
      $onehot0(o_debug.prog_pin_pair)) else $error("pin pairs not one-hot");
   a_bor_lp: assert property (
      !(o_power.brownout_reset_en && o_power.low_power_brownout_on)) else $error("both detectors");
   a_debug_hold: assert property (
      up_reg == 3'h7 |=> $stable(o_debug)) else $error("debug settings moved");
   a_wdog_hold: assert property (
      up_reg == 3'h7 |=> $stable({o_wdog.watchdog_on, o_wdog.windowed})) else $error("wdog moved");
   a_win_code: assert property (
      up_reg == 3'h7 |-> o_wdog.window_eighths inside {4'h2, 4'h3, 4'h4, 4'h6}) else $error("win");
endmodule

// [test/cwd_testbench.sv]
// bench for the configuration word decoder
`timescale 1ns/10ps
module testbench;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_sleep = 1'b0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic [31:0] dw = '1;
   logic [31:0] pw = '1;
   logic [31:0] ww = '1;
   logic [31:0] o_rdata;
   cwd_pkg::cwd_debug_t o_debug;
   cwd_pkg::cwd_power_t o_power;
   cwd_pkg::cwd_wdog_t o_wdog;
   logic [20:0] o_timeout_ticks;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   cwd_config_word_decode dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_debug_word(dw),
      .i_power_word(pw), .i_wdog_word(ww), .i_sleep(i_sleep), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_debug(o_debug),
      .o_power(o_power), .o_wdog(o_wdog), .o_timeout_ticks(o_timeout_ticks));
   initial forever #2.5 i_clk = ~i_clk;
   // ==========
   task automatic end_sim();
      if (miscompares == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // the run needs about 320 cycles
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one bus cycle; a read compares the data of the following cycle
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= w;
      i_rd <= !w;
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      @(negedge i_clk);
      if (!w) chk("o_rdata", o_rdata, d);
   endtask
   // words only take effect through a reset, so every case reloads
   task automatic load(input logic [31:0] d, p, w, c, input logic s);
      @(posedge i_clk);
      dw <= d;
      pw <= p;
      ww <= w;
      i_sleep <= s;
      i_sys_rst <= 1'b1;
      @(posedge i_clk);
      i_sys_rst <= 1'b0;
      acc(1'b1, cwd_pkg::ADDR_RUNCTL, c);
      repeat (6) @(posedge i_clk);
      @(negedge i_clk);
   endtask
   // ==========
   task automatic t_debug();
      logic [2:0] pins;
      for (int c = 0; c < 4; c++) begin
         pins = (c == 3) ? 3'h1 : (c == 2) ? 3'h2 : (c == 1) ? 3'h4 : 3'h0;
         load({27'h7ffffff, c[1:0], c[0], 2'h3}, '1, '1, 32'h0, 1'b0);
         chk("o_debug", 32'(o_debug), {28'h0, pins, c[0]});
      end
   endtask
   task automatic t_brown();
      logic bor;
      logic lp;
      logic [31:0] x;
      for (int i = 0; i < 16; i++) begin
         bor = i[1:0] == 2'h3 || (i[1:0] == 2'h2 && !i[2]) || (i[1:0] == 2'h1 && i[3]);
         lp = i[1] | !i[3];
         load('1, {28'hfffffff, lp, i[0], i[1:0]}, '1, {30'h0, 1'b1, i[3]}, i[2]);
         x = {29'h0, bor, lp & !bor, !i[0] & i[2]};
         chk("o_power", 32'(o_power), x);
      end
   endtask
   task automatic t_wdog();
      logic [4:0] run;
      logic [4:0] e;
      logic [3:0] win;
      logic [31:0] x;
      for (int i = 0; i < 8; i++) begin
         run = (i[1:0] == 2'h0) ? 5'h13 : (i[1:0] == 2'h1) ? 5'h14 : (i[1:0] == 2'h2) ? 5'h1f : 5'h0;
         e = i[2] ? run + 5'h1 : run;
         e = (e > 5'h14) ? 5'h14 : e;
         win = (i[1:0] == 2'h3) ? 4'h2 : (i[1:0] == 2'h2) ? 4'h3 : (i[1:0] == 2'h1) ? 4'h4 : 4'h6;
         load('1, '1, {16'hffff, i[1], i[1:0], run, i[0], i[1:0], run + 5'h1}, 32'h0, i[2]);
         x = {19'h0, i[1], i[2] ? 2'h3 : i[1:0], !i[0], win, e};
         chk("o_wdog", 32'(o_wdog), x);
         chk("o_wdog.postscale_exp", 32'(o_wdog.postscale_exp), 32'(e));
         chk("o_timeout_ticks", 32'(o_timeout_ticks), 32'h1 << e);
      end
   endtask
   task automatic t_regs();
      load(32'hffffffef, 32'hfffffff5, 32'hffffa5e3, 32'h0, 1'b0);
      acc(1'b0, cwd_pkg::ADDR_DEBUG, 32'hffffffef);
      acc(1'b0, cwd_pkg::ADDR_POWER, 32'hfffffff5);
      acc(1'b1, cwd_pkg::ADDR_WDOG, 32'h0);
      acc(1'b0, cwd_pkg::ADDR_WDOG, 32'hffffa5e3);
      acc(1'b0, 4'hf, 32'h0);
      acc(1'b0, cwd_pkg::ADDR_STATUS, 32'h1e0);
      acc(1'b0, cwd_pkg::ADDR_TIMEOUT, 32'h20);
      acc(1'b1, cwd_pkg::ADDR_RUNCTL, 32'h5);
      acc(1'b0, cwd_pkg::ADDR_RUNCTL, 32'h5);
      chk("o_power", 32'(o_power), 32'h4);
      dw <= 32'h0;
      ww <= 32'h0;
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      chk("o_wdog", 32'(o_wdog), 32'h1445);
   endtask
   initial begin
      repeat (10) @(posedge i_clk);
      t_debug();
      t_brown();
      t_wdog();
      t_regs();
      end_sim();
   end
endmodule
bind cwd_config_word_decode cwd_assertions chk_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_rd(i_rd), .i_addr(i_addr), .o_rdata(o_rdata), .o_debug(o_debug), .o_power(o_power),
   .o_wdog(o_wdog), .o_timeout_ticks(o_timeout_ticks));
